/* hdl/ccdec_defs.svh */
`ifndef CCDEC_DEFS_SVH
`define CCDEC_DEFS_SVH
// register indices (offsets 0x1c/0x1d are indices, address = 4 * index)
`define CCDEC_IDX_MAIN_STATUS 8'h00
`define CCDEC_IDX_CC_CTRL 8'h1c
`define CCDEC_IDX_CAPTION_READ_DATA 8'h1d
`define CCDEC_IDX_LINE_CFG 8'h1e
// caption_control_status fields
`define CCDEC_CTL_CC_EN 0
`define CCDEC_CTL_EDS_EN 1
`define CCDEC_CTL_IRQ_EN 2
`define CCDEC_ST_KIND 3
`define CCDEC_ST_HALF 4
`define CCDEC_ST_PERR 5
`define CCDEC_ST_DA 6
`define CCDEC_ST_OVR 7
// main_status field
`define CCDEC_MS_HALF_FULL 0
// control reset value and fixed capture lines
`define CCDEC_CTL_RESET 3'h0
`define CCDEC_CC_LINE 10'd21
`define CCDEC_EDS_LINE 10'd284
// run-in / bit timing in sample-enable ticks
`define CCDEC_RUNIN_EDGES 4'd6
`define CCDEC_BIT_TICKS 6'd32
`define CCDEC_SEARCH_TICKS 12'd1500
`endif

/* hdl/ccdec_pkg.sv */
package ccdec_pkg;
  typedef enum logic [5:0] {
    CCDEC_IDLE = 6'b000001,
    CCDEC_RUNIN = 6'b000010,
    CCDEC_START = 6'b000100,
    CCDEC_BYTE = 6'b001000,
    CCDEC_STORE = 6'b010000,
    CCDEC_DONE = 6'b100000
  } ccdec_state_t;
  typedef struct packed {
    logic kind;
    logic half;
    logic [7:0] data;
  } ccdec_entry_t;
endpackage : ccdec_pkg

/* hdl/ccdec_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ccdec_fifo_if;
  import ccdec_pkg::*;
  logic wr_req;
  ccdec_entry_t wr_data;
  logic rd_req;
  logic flush;
  ccdec_entry_t rd_data;
  logic empty;
  logic full;
  logic half_full;
  logic wr_dropped;
  modport owner (output wr_req, wr_data, rd_req, flush,
    input rd_data, empty, full, half_full, wr_dropped);
  modport store (input wr_req, wr_data, rd_req, flush,
    output rd_data, empty, full, half_full, wr_dropped);
endinterface : ccdec_fifo_if
`default_nettype wire

/* hdl/ccdec_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module ccdec_fifo
  import ccdec_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  ccdec_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ccdec_fifo: DEPTH must be a power of two >= 2");
  end
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    ccdec_entry_t rd_data;
  } ccdec_fifo_st_t;
  ccdec_fifo_st_t st;
  ccdec_fifo_st_t next_st;
  ccdec_entry_t mem [DEPTH];
  logic [AW:0] count;
  logic do_rd;
  logic do_wr;
  // ----------------------------------------
  // control
  // ----------------------------------------
  assign count = st.wp - st.rp;
  assign f.empty = (count == '0);
  assign f.full = (count == (AW + 1)'(DEPTH));
  assign f.half_full = (count >= (AW + 1)'(DEPTH / 2));
  assign do_rd = f.rd_req && !f.empty;
  // read priority: a write that meets a read on a full store is dropped
  assign do_wr = f.wr_req && !f.full;
  assign f.wr_dropped = f.wr_req && f.full;
  assign f.rd_data = st.rd_data;
  always_comb begin
    next_st = st;
    if (f.flush) begin
      next_st.wp = '0;
      next_st.rp = '0;
    end else begin
      if (do_wr) next_st.wp = st.wp + 1'b1;
      if (do_rd) next_st.rp = st.rp + 1'b1;
    end
    // head word registered: oldest entry, or the word being written into an empty store
    if (f.flush) next_st.rd_data = '0;
    else if (next_st.wp == next_st.rp) next_st.rd_data = '0;
    else if (next_st.rp == st.wp) next_st.rd_data = f.wr_data;
    else next_st.rd_data = mem[next_st.rp[AW-1:0]];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st <= '0;
    else st <= next_st;
  end
  always_ff @(posedge pclk) begin
    if (do_wr && !f.flush) mem[st.wp[AW-1:0]] <= f.wr_data;
  end
endmodule : ccdec_fifo
`default_nettype wire

/* hdl/ccdec_top.sv */
// Notes on behaviour
// - capture caption bytes on line 21, extended data on line 284.
// - decoder only looks at the separated luma sample stream.
// - caption and extended-data captures each have their own enable.
// - at target line, find run-in, then start code 001, then capture.
// - each byte is seven ASCII bits plus an odd-parity bit.
// - parity bit kept in entry; check result shown as parity-error bit.
// - sixteen entries of ten bits, eight lines of two bytes.
// - low byte first, stored only if not full; high byte next.
// - entries tagged caption/extended and low/high, readable in status.
// - data-available low when empty, high once a byte is stored.
// - half full raises interrupt pin if enabled; flag in main status.
// - oldest byte shows at once; each data read advances one entry.
// - byte arriving on full store is dropped, overflow bit set.
// - host clears overflow by reading data to free space.
// - simultaneous read and write: read has priority.
// - clearing read that meets a write leaves overflow set.
// - both enables off holds the store in reset, contents lost.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ccdec_defs.svh"
module ccdec_top
  import ccdec_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter logic [7:0] SLICE_LEVEL = 8'h40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic luma_valid,
  input wire logic [7:0] luma,
  input wire logic line_start,
  input wire logic odd_field,
  input wire logic [9:0] line_num,
  output logic caption_half_full_irq
);
  initial begin
    if (DEPTH != 16) $error("ccdec_top: tag layout assumes a 16-entry store");
  end
  typedef struct packed {
    ccdec_state_t fsm;
    logic [2:0] ctrl;
    logic [11:0] tmo;
    logic [5:0] tick;
    logic [3:0] edges;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [2:0] startbits;
    logic last_bit;
    logic kind;
    logic half;
    logic parity_err;
    logic ovr;
    logic ovr_clr_pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } ccdec_top_st_t;
  ccdec_top_st_t st;
  ccdec_top_st_t next_st;
  ccdec_fifo_if fi ();
  ccdec_fifo #(
    .DEPTH(DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .f(fi)
  );
  logic bit_now;
  logic setup;
  logic [7:0] idx;
  logic on_line;
  logic is_cc_line;
  logic is_eds_line;
  logic data_rd;
  logic wr_pulse;
  logic [7:0] ccs;
  assign bit_now = (luma >= SLICE_LEVEL);
  assign setup = psel && !penable;
  assign idx = paddr[9:2];
  // ----------------------------------------
  // line selection
  // ----------------------------------------
  assign is_cc_line = st.ctrl[`CCDEC_CTL_CC_EN] && odd_field && line_num == `CCDEC_CC_LINE;
  assign is_eds_line = st.ctrl[`CCDEC_CTL_EDS_EN] && !odd_field
    && line_num == `CCDEC_EDS_LINE;
  assign on_line = is_cc_line || is_eds_line;
  assign data_rd = setup && !pwrite && idx == `CCDEC_IDX_CAPTION_READ_DATA;
  assign wr_pulse = (st.fsm == CCDEC_STORE);
  // single clock: capture and host share pclk, so pointers need no crossing
  assign fi.rd_req = data_rd;
  assign fi.wr_req = wr_pulse;
  assign fi.wr_data = '{kind: st.kind, half: st.half, data: st.shreg};
  assign fi.flush = !st.ctrl[`CCDEC_CTL_CC_EN] && !st.ctrl[`CCDEC_CTL_EDS_EN];
  always_comb begin
    ccs = 8'h00;
    ccs[`CCDEC_CTL_CC_EN] = st.ctrl[`CCDEC_CTL_CC_EN];
    ccs[`CCDEC_CTL_EDS_EN] = st.ctrl[`CCDEC_CTL_EDS_EN];
    ccs[`CCDEC_CTL_IRQ_EN] = st.ctrl[`CCDEC_CTL_IRQ_EN];
    ccs[`CCDEC_ST_KIND] = fi.rd_data.kind;
    ccs[`CCDEC_ST_HALF] = fi.rd_data.half;
    ccs[`CCDEC_ST_PERR] = st.parity_err;
    ccs[`CCDEC_ST_DA] = !fi.empty;
    ccs[`CCDEC_ST_OVR] = st.ovr;
  end
  // ----------------------------------------
  // decoder and register logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (luma_valid) begin
      next_st.tick = st.tick + 6'd1;
    end
    case (st.fsm)
      CCDEC_IDLE: begin
        if (line_start && on_line) begin
          next_st.fsm = CCDEC_RUNIN;
          next_st.kind = is_eds_line;
          next_st.edges = '0;
          next_st.tmo = '0;
          next_st.last_bit = 1'b0;
        end
      end
      CCDEC_RUNIN: begin
        if (luma_valid) begin
          next_st.tmo = st.tmo + 12'd1;
          next_st.last_bit = bit_now;
          if (bit_now && !st.last_bit) begin
            next_st.edges = st.edges + 4'd1;
            next_st.tick = '0;
          end
          if (st.edges == `CCDEC_RUNIN_EDGES && st.tick == `CCDEC_BIT_TICKS) begin
            next_st.fsm = CCDEC_START;
            next_st.tick = '0;
            next_st.startbits = '0;
            next_st.bitn = '0;
          end else if (st.tmo == `CCDEC_SEARCH_TICKS) begin
            next_st.fsm = CCDEC_IDLE;
          end
        end
      end
      CCDEC_START: begin
        if (luma_valid && st.tick == (`CCDEC_BIT_TICKS >> 1)) begin
          next_st.startbits = {st.startbits[1:0], bit_now};
          next_st.bitn = st.bitn + 4'd1;
        end
        if (st.bitn == 4'd3) begin
          if (st.startbits == 3'b001) begin
            next_st.fsm = CCDEC_BYTE;
            next_st.half = 1'b0;
            next_st.bitn = '0;
          end else begin
            next_st.fsm = CCDEC_IDLE;
          end
        end
        if (luma_valid && st.tick == `CCDEC_BIT_TICKS - 6'd1) next_st.tick = '0;
      end
      CCDEC_BYTE: begin
        if (luma_valid && st.tick == (`CCDEC_BIT_TICKS >> 1)) begin
          // lsb first; eighth bit is the parity bit and stays in the entry
          next_st.shreg = {bit_now, st.shreg[7:1]};
          next_st.bitn = st.bitn + 4'd1;
        end
        if (luma_valid && st.tick == `CCDEC_BIT_TICKS - 6'd1) next_st.tick = '0;
        if (st.bitn == 4'd8) begin
          next_st.fsm = CCDEC_STORE;
          next_st.parity_err = !(^st.shreg);
        end
      end
      CCDEC_STORE: begin
        // low byte dropped when full; high byte still follows
        next_st.bitn = '0;
        next_st.fsm = st.half ? CCDEC_DONE : CCDEC_BYTE;
        next_st.half = 1'b1;
      end
      CCDEC_DONE: begin
        if (!on_line) next_st.fsm = CCDEC_IDLE;
      end
      default: next_st.fsm = CCDEC_IDLE;
    endcase
    if (fi.flush && st.fsm != CCDEC_IDLE) next_st.fsm = CCDEC_IDLE;
    // overflow: set wins, a clearing read that meets a write leaves it set
    if (fi.wr_dropped) begin
      next_st.ovr = 1'b1;
      next_st.ovr_clr_pend = 1'b0;
    end else if (st.ovr && data_rd && !fi.empty) begin
      if (wr_pulse) next_st.ovr_clr_pend = 1'b0;
      else next_st.ovr = 1'b0;
    end
    if (fi.flush) next_st.ovr = 1'b0;
    // host side
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      if (pwrite) begin
        case (idx)
          `CCDEC_IDX_CC_CTRL: next_st.ctrl = pwdata[2:0];
          `CCDEC_IDX_MAIN_STATUS, `CCDEC_IDX_LINE_CFG: next_st.ctrl = st.ctrl;
          default: next_st.pslverr = 1'b1;
        endcase
      end else begin
        case (idx)
          `CCDEC_IDX_MAIN_STATUS: next_st.prdata[`CCDEC_MS_HALF_FULL] = fi.half_full;
          `CCDEC_IDX_CC_CTRL: next_st.prdata[7:0] = ccs;
          `CCDEC_IDX_CAPTION_READ_DATA: next_st.prdata[7:0] = fi.rd_data.data;
          `CCDEC_IDX_LINE_CFG: next_st.prdata[9:0] = line_num;
          default: next_st.pslverr = 1'b1;
        endcase
      end
    end
    next_st.irq = fi.half_full && st.ctrl[`CCDEC_CTL_IRQ_EN];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= CCDEC_IDLE;
      st.ctrl <= `CCDEC_CTL_RESET;
    end else begin
      st <= next_st;
    end
  end
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign caption_half_full_irq = st.irq;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_store_on_full;
    wr_pulse && fi.full && !data_rd;
  endsequence
  AST_OVR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    s_store_on_full |=> st.ovr) else $error("overflow not set on full write");
  AST_OVR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (st.ovr && data_rd && wr_pulse && !fi.flush) |=> st.ovr)
    else $error("overflow cleared despite write");
  AST_OVR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (st.ovr && data_rd && !fi.empty && !wr_pulse && !fi.wr_dropped) |=> !st.ovr)
    else $error("overflow not cleared by read");
  AST_FLUSH: assert property (@(posedge pclk) disable iff (!presetn)
    fi.flush |=> fi.empty) else $error("store not emptied when disabled");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    caption_half_full_irq |-> $past(fi.half_full && st.ctrl[`CCDEC_CTL_IRQ_EN]))
    else $error("irq without half full");
  AST_DA: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pulse && !fi.full && !fi.flush) |=> !fi.empty) else $error("data not available");
  AST_RD_PRIO: assert property (@(posedge pclk) disable iff (!presetn)
    (data_rd && !fi.empty && wr_pulse && fi.full && !fi.flush) |=> fi.full == 1'b0)
    else $error("read lost priority");
  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready) else $error("pready not one cycle");
  AST_LINE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.fsm == CCDEC_RUNIN) |-> $past(on_line && line_start))
    else $error("capture on wrong line");
endmodule : ccdec_top
`default_nettype wire

/* tb/ccdec_luma_src.sv */
`timescale 1ns/100ps
`default_nettype none
module ccdec_luma_src (
  input wire logic pclk,
  output logic luma_valid,
  output logic [7:0] luma,
  output logic line_start,
  output logic odd_field,
  output logic [9:0] line_num
);
  logic busy = 1'b0;
  logic [7:0] lvl = 8'h10;
  logic [5:0] pat = 6'h00;
  initial begin
    luma_valid = 1'b0;
    line_start = 1'b0;
    odd_field = 1'b0;
    line_num = 10'h000;
  end
  // between lines the sample keeps moving below the slice level
  always @(posedge pclk) begin
    pat <= pat + 6'h01;
  end
  assign luma = busy ? lvl : {2'b00, pat};
  task automatic send_line(input logic odd, input logic [9:0] num, input logic [7:0] lo,
    input logic [7:0] hi);
    logic [18:0] bits;
    bits = {hi, lo, 3'b100};
    @(posedge pclk);
    line_start <= 1'b1;
    odd_field <= odd;
    line_num <= num;
    busy <= 1'b1;
    luma_valid <= 1'b1;
    lvl <= 8'h10;
    @(posedge pclk);
    line_start <= 1'b0;
    repeat (15) @(posedge pclk);
    repeat (6) begin
      lvl <= 8'hc0;
      repeat (16) @(posedge pclk);
      lvl <= 8'h10;
      repeat (16) @(posedge pclk);
    end
    for (int i = 0; i < 19; i++) begin
      lvl <= bits[i] ? 8'hc0 : 8'h10;
      repeat (32) @(posedge pclk);
    end
    busy <= 1'b0;
    luma_valid <= 1'b0;
    // move on to the next line so the decoder leaves its done state
    line_num <= num + 10'd1;
    repeat (40) @(posedge pclk);
  endtask : send_line
endmodule : ccdec_luma_src
`default_nettype wire

/* tb/caption_data_decoder_fifo_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ccdec_defs.svh"
module caption_data_decoder_fifo_tb;
  typedef struct packed {
    logic [2:0] ctl;
    logic odd;
    logic [9:0] num;
    logic [6:0] lo;
    logic [6:0] hi;
    logic keep;
    logic kind;
  } ccdec_row_t;
  localparam logic [7:0] CTL = `CCDEC_IDX_CC_CTRL;
  localparam logic [7:0] DAT = `CCDEC_IDX_CAPTION_READ_DATA;
  localparam logic [7:0] MS = `CCDEC_IDX_MAIN_STATUS;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, luma_valid, line_start, odd_field, irq, e;
  logic [7:0] luma;
  logic [9:0] line_num, x;
  logic [9:0] q[$];
  int err_count = 0, tests_run = 0;
  ccdec_row_t rows[6] = '{
    '{3'h1, 1'b1, 10'd21, 7'h41, 7'h42, 1'b1, 1'b0},
    '{3'h2, 1'b0, 10'd284, 7'h05, 7'h7f, 1'b1, 1'b1},
    '{3'h2, 1'b1, 10'd21, 7'h10, 7'h11, 1'b0, 1'b0},
    '{3'h1, 1'b0, 10'd284, 7'h12, 7'h13, 1'b0, 1'b0},
    '{3'h3, 1'b1, 10'd22, 7'h14, 7'h15, 1'b0, 1'b0},
    '{3'h3, 1'b0, 10'd284, 7'h00, 7'h7e, 1'b1, 1'b1}};
  ccdec_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .luma_valid(luma_valid), .luma(luma), .line_start(line_start),
    .odd_field(odd_field), .line_num(line_num), .caption_half_full_irq(irq));
  ccdec_luma_src src (.pclk(pclk), .luma_valid(luma_valid), .luma(luma),
    .line_start(line_start), .odd_field(odd_field), .line_num(line_num));
  initial begin
    forever #25 pclk = ~pclk;
  end
  function automatic logic [7:0] enc(input logic [6:0] d);
    return {~^d, d};
  endfunction : enc
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      print_verdict();
    end
  endtask : apb
  // status must be read before data: a data read pops the head entry
  task automatic drain(input logic [2:0] ctl);
    while (q.size() > 0) begin
      x = q.pop_front();
      apb(1'b0, CTL, 32'h0);
      chk("status", {24'h0, 3'b010, x[8], x[9], ctl}, r);
      apb(1'b0, DAT, 32'h0);
      chk("data", {24'h0, x[7:0]}, r);
    end
    apb(1'b0, CTL, 32'h0);
    chk("da_empty", 32'h0, {31'h0, r[`CCDEC_ST_DA]});
  endtask : drain
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTL, 32'h0);
    chk("ctl_reset", 32'h0, r);
    apb(1'b0, MS, 32'h0);
    chk("main_reset", 32'h0, r);
    apb(1'b0, 8'hff, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CTL, {29'h0, rows[i].ctl});
      src.send_line(rows[i].odd, rows[i].num, enc(rows[i].lo), enc(rows[i].hi));
      if (rows[i].keep) begin
        q.push_back({rows[i].kind, 1'b0, enc(rows[i].lo)});
        q.push_back({rows[i].kind, 1'b1, enc(rows[i].hi)});
      end
      drain(rows[i].ctl);
    end
    // bad parity on both bytes, then drop the high byte by disabling capture
    apb(1'b1, CTL, 32'h1);
    src.send_line(1'b1, 10'd21, enc(7'h23) ^ 8'h80, enc(7'h24) ^ 8'h80);
    apb(1'b0, CTL, 32'h0);
    chk("perr", 32'h61, r);
    apb(1'b0, DAT, 32'h0);
    chk("raw_parity", {24'h0, enc(7'h23) ^ 8'h80}, r);
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CTL, 32'h1);
    apb(1'b0, CTL, 32'h0);
    chk("flushed", 32'h0, {31'h0, r[`CCDEC_ST_DA]});
    apb(1'b1, CTL, 32'h5);
    for (int i = 0; i < 9; i++) begin
      src.send_line(1'b1, 10'd21, enc(i[6:0]), enc(i[6:0] + 7'h20));
      if (i == 2)
        chk("irq_below", 32'h0, {31'h0, irq});
      if (i == 3) begin
        chk("irq_half", 32'h1, {31'h0, irq});
        apb(1'b0, MS, 32'h0);
        chk("ms_half", 32'h1, r);
      end
      if (i < 8) begin
        q.push_back({2'b00, enc(i[6:0])});
        q.push_back({2'b01, enc(i[6:0] + 7'h20)});
      end
    end
    apb(1'b0, CTL, 32'h0);
    chk("ovr_set", 32'hc5, r);
    x = q.pop_front();
    apb(1'b0, DAT, 32'h0);
    chk("head", {24'h0, x[7:0]}, r);
    apb(1'b0, CTL, 32'h0);
    chk("ovr_clr", 32'h55, r);
    drain(3'h5);
    chk("irq_off", 32'h0, {31'h0, irq});
    print_verdict();
  end
endmodule : caption_data_decoder_fifo_tb
`default_nettype wire
